/* shared/car_defs.vh */
/*
  Constants for the configuration access router: host port addresses, index
  register fields, window sizing, routing codes and internal device numbers.
  Assumes inclusion by bare name from the route decoder, the router and the bench files.
*/
// Function
// - Host I/O dword range 0CF8h-0CFBh decodes as the configuration index register.
// - Host I/O range 0CFCh-0CFFh decodes as the configuration data window.
// - Configuration cycles only when index bit 31 is set; otherwise none.
// - Every data window read or write becomes a cycle to the indexed dword.
// - Each function has 4096 bytes; lowest 256 compatible, rest extended.
// - Extended region reachable only via memory window; compatible region via both.
// - Locked accesses to the memory window are unsupported and get no handling.
// - Writes through either method reach the same register state identically.
// - Window is 256 MB by default, or 128 MB or 64 MB limiting buses.
// - Enhanced window active only after enable bit 0 and base programmed.
// - Window address is base plus bus*1MB, device*32KB, function*4KB, offset.
// - Requests carry 4-bit upper register index; zero for legacy accesses.
// - Bus zero naming an existing enabled internal device is claimed internally.
// - TLP header: bus byte 8, device/function byte 9, upper index 10, register 11.
// - Bus equal to secondary bus goes to the root link as Type 0.
// - Type 0 root link access to non-zero device is master-aborted.
// - Bus above secondary, at or below subordinate, goes to root link Type 1.
// - Extended writes complete posted on host bus, non-posted downstream.
// - Disabled internal, bus-zero devices 2-31, unclaimed buses go to chipset link.
// - Chipset link uses Type 0 for bus zero, Type 1 otherwise.
// - Unclaimed chipset link configuration accesses end as master abort.
// - Byte or word index-port accesses do not update it; forwarded as I/O.
// - Internal-device cycles with non-zero function number are ignored.
`ifndef CAR_DEFS_VH
`define CAR_DEFS_VH

`define CAR_IO_INDEX        16'h0cf8
`define CAR_IO_DATA         16'h0cfc
`define CAR_INDEX_RESET     32'h0000_0000
`define CAR_INDEX_ENABLE    31
`define CAR_COMPAT_BYTES    13'h100
`define CAR_FUNC_BYTES      13'h1000
`define CAR_EWB_RESET       32'h0000_0000
`define CAR_EWB_EN_BIT      0
`define CAR_SIZE_256        2'h0
`define CAR_SIZE_128        2'h1
`define CAR_SIZE_64         2'h2

// Route codes
`define CAR_RT_NONE         3'h0
`define CAR_RT_INTERNAL     3'h1
`define CAR_RT_ROOT_T0      3'h2
`define CAR_RT_ROOT_T1      3'h3
`define CAR_RT_LINK_T0      3'h4
`define CAR_RT_LINK_T1      3'h5
`define CAR_RT_ABORT        3'h6
`define CAR_RT_IGNORE       3'h7

// Internal device numbers on bus zero
`define CAR_DEV_HOST        5'h00
`define CAR_DEV_BRIDGE      5'h01

`endif

/* logic/car_route_decode.v */
/*
  Combinational route decision for one configuration request.
  Assumes bus window registers and device enables are stable during decode.
*/
`timescale 1ns/1ps
`include "car_defs.vh"

module car_route_decode (
  input  wire [7:0] bus,
  input  wire [4:0] dev,
  input  wire [2:0] func,
  input  wire [7:0] sec_bus,
  input  wire [7:0] sub_bus,
  input  wire       dev0_en,
  input  wire       dev1_en,
  output reg  [2:0] route
);
  wire internal_hit;

  assign internal_hit = (dev == `CAR_DEV_HOST && dev0_en) ||
                        (dev == `CAR_DEV_BRIDGE && dev1_en);

  always @* begin
    route = `CAR_RT_LINK_T1;
    if (bus == 8'h00) begin
      if (internal_hit) begin
        if (func != 3'h0)
          route = `CAR_RT_IGNORE;
        else
          route = `CAR_RT_INTERNAL;
      end else begin
        route = `CAR_RT_LINK_T0;
      end
    end else if (bus == sec_bus) begin
      if (dev != 5'h00)
        route = `CAR_RT_ABORT;
      else
        route = `CAR_RT_ROOT_T0;
    end else if (bus > sec_bus && bus <= sub_bus) begin
      route = `CAR_RT_ROOT_T1;
    end else begin
      route = `CAR_RT_LINK_T1;
    end
  end
endmodule // car_route_decode

/* logic/car_tlp_header.v */
/*
  Packs the configuration-specific dword of a TLP header (bytes 8 to 11).
  Assumes fields are already validated by the router.
*/
`timescale 1ns/1ps

module car_tlp_header (
  input  wire [7:0]  bus,
  input  wire [4:0]  dev,
  input  wire [2:0]  func,
  input  wire [3:0]  upper_register_index,
  input  wire [5:0]  reg_num,
  output wire [31:0] hdr_dw2
);
  // Byte 8 is the most significant byte of the third header dword
  assign hdr_dw2 = {bus, dev, func, 4'h0, upper_register_index, reg_num, 2'b00};
endmodule // car_tlp_header

/* logic/car_config_access_router.v */
/*
  Configuration access router: turns host_front_bus I/O accesses to the index
  and data ports, and memory accesses into the enhanced window, into routed
  configuration requests for internal devices, the root link or chipset_link.
  Assumes a host access is a one-cycle strobe and the downstream side answers
  each request with a done pulse carrying read data or a master-abort flag.
*/
`timescale 1ns/1ps
`include "car_defs.vh"

module car_config_access_router (
  input  wire        clk,
  input  wire        reset_n,
  // Host I/O access
  input  wire        io_req,
  input  wire        io_write,
  input  wire [15:0] io_addr,
  input  wire [3:0]  io_be,
  input  wire [31:0] io_wdata,
  // Host memory access
  input  wire        mem_req,
  input  wire        mem_write,
  input  wire [35:0] mem_addr,
  input  wire [3:0]  mem_be,
  input  wire [31:0] mem_wdata,
  // Host answer
  output reg         host_done,
  output reg  [31:0] host_rdata,
  output reg         host_abort,
  output wire        host_busy,
  // Memory access not inside the window, left for other decoders
  output wire        mem_miss,
  // Byte/word index port pass-through to chipset link as plain I/O
  output reg         io_pass,
  output reg  [15:0] io_pass_addr,
  output reg  [3:0]  io_pass_be,
  output reg         io_pass_write,
  output reg  [31:0] io_pass_wdata,
  // Bridge bus window and internal device enables
  input  wire [7:0]  sec_bus,
  input  wire [7:0]  sub_bus,
  input  wire        dev0_en,
  input  wire        dev1_en,
  // Enhanced window size selection
  input  wire [1:0]  window_size,
  // Enhanced window base register write (internal device 0 register)
  input  wire        ewb_write,
  input  wire [31:0] ewb_wdata,
  output reg  [31:0] enhanced_window_base_reg,
  // Configuration request out
  output reg         cfg_req,
  output reg  [2:0]  cfg_route,
  output reg         cfg_write,
  output reg  [3:0]  cfg_be,
  output reg  [31:0] cfg_wdata,
  output reg  [31:0] cfg_hdr_dw2,
  output reg  [7:0]  cfg_bus,
  output reg  [4:0]  cfg_dev,
  output reg  [2:0]  cfg_func,
  output reg  [9:0]  cfg_offset,
  input  wire        cfg_done,
  input  wire        cfg_abort,
  input  wire [31:0] cfg_rdata,
  // Current index register contents
  output reg  [31:0] config_index_port
);
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;

  reg  [1:0]  state;
  reg         pend_posted;
  reg  [7:0]  bus;
  reg  [4:0]  dev;
  reg  [2:0]  func;
  reg  [3:0]  upper_idx;
  reg  [5:0]  reg_num;
  reg         start;
  reg         start_write;
  reg  [3:0]  start_be;
  reg  [31:0] start_wdata;
  reg         start_posted;
  reg  [7:0]  bus_mask;
  wire [2:0]  route;
  wire [31:0] hdr;
  wire        io_index_hit;
  wire        io_data_hit;
  wire        ewb_en;
  wire        win_hit;
  wire        io_cfg;
  wire        idx_dword;
  wire        idx_part;
  wire        win_base_hit;
  wire        win_bus_hit;
  wire [7:0]  ix_bus;
  wire [4:0]  ix_dev;
  wire [2:0]  ix_func;
  wire [5:0]  ix_reg;
  wire [7:0]  win_bus;
  wire [4:0]  win_dev;
  wire [2:0]  win_func;
  wire [3:0]  win_upper;
  wire [5:0]  win_reg;

  assign io_index_hit = io_req && {io_addr[15:2], 2'b00} == `CAR_IO_INDEX;
  assign io_data_hit  = io_req && {io_addr[15:2], 2'b00} == `CAR_IO_DATA;
  assign ewb_en       = enhanced_window_base_reg[`CAR_EWB_EN_BIT];
  // Only a full dword reaches the index register; narrower accesses are
  // plain I/O for the chipset link and must leave the selection alone.
  assign idx_dword    = io_index_hit && io_be == 4'hf;
  assign idx_part     = io_index_hit && io_be != 4'hf;

  // Legacy selection from the index register; its upper index stays zero
  assign ix_bus  = config_index_port[23:16];
  assign ix_dev  = config_index_port[15:11];
  assign ix_func = config_index_port[10:8];
  assign ix_reg  = config_index_port[7:2];

  always @* begin
    case (window_size)
      `CAR_SIZE_128: bus_mask = 8'h7f;
      `CAR_SIZE_64:  bus_mask = 8'h3f;
      default:       bus_mask = 8'hff;
    endcase
  end

  // Window base bits above the window size must match; bus bits beyond the
  // size belong to the base and are compared instead of decoded.
  // No lock qualifier exists: a locked access is decoded like any other
  assign win_base_hit = mem_addr[35:28] == enhanced_window_base_reg[31:24];
  assign win_bus_hit  = (mem_addr[27:20] & ~bus_mask) ==
                        (enhanced_window_base_reg[23:16] & ~bus_mask);
  assign win_hit      = mem_req && ewb_en && win_base_hit && win_bus_hit;

  // Window selection: bus, device, function and 4 KB offset from the address
  assign win_bus   = mem_addr[27:20] & bus_mask;
  assign win_dev   = mem_addr[19:15];
  assign win_func  = mem_addr[14:12];
  assign win_upper = mem_addr[11:8];
  assign win_reg   = mem_addr[7:2];
  assign mem_miss = mem_req && !win_hit;
  assign io_cfg   = io_data_hit && config_index_port[`CAR_INDEX_ENABLE];
  // Strobes other than index accesses are dropped while this is high
  assign host_busy = (state != ST_IDLE);

  // Capture the request fields from whichever mechanism fired
  // The window wins over an enabled data port cycle in the same cycle; index dword and disabled data port accesses beat it
  always @* begin
    start        = 1'b0;
    start_write  = 1'b0;
    start_be     = 4'h0;
    start_wdata  = 32'h0000_0000;
    start_posted = 1'b0;
    bus          = ix_bus;
    dev          = ix_dev;
    func         = ix_func;
    upper_idx    = 4'h0;
    reg_num      = ix_reg;
    if (state == ST_IDLE) begin
      if (win_hit) begin
        start        = 1'b1;
        start_write  = mem_write;
        start_be     = mem_be;
        start_wdata  = mem_wdata;
        start_posted = mem_write;
        bus          = win_bus;
        dev          = win_dev;
        func         = win_func;
        upper_idx    = win_upper;
        reg_num      = win_reg;
      end else if (io_cfg) begin
        start       = 1'b1;
        start_write = io_write;
        start_be    = io_be;
        start_wdata = io_wdata;
      end
    end
  end

  car_route_decode u_route (
    .bus     (bus),
    .dev     (dev),
    .func    (func),
    .sec_bus (sec_bus),
    .sub_bus (sub_bus),
    .dev0_en (dev0_en),
    .dev1_en (dev1_en),
    .route   (route)
  );

  car_tlp_header u_hdr (
    .bus                  (bus),
    .dev                  (dev),
    .func                 (func),
    .upper_register_index (upper_idx),
    .reg_num              (reg_num),
    .hdr_dw2              (hdr)
  );

  // Index port and enhanced window base register
  // The index loads even while busy, but such an access gets no answer,
  // so hosts must wait for host_busy to fall before touching it.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      config_index_port        <= `CAR_INDEX_RESET;
      enhanced_window_base_reg <= `CAR_EWB_RESET;
    end else begin
      if (idx_dword && io_write)
        config_index_port <= {io_wdata[31], 7'h00, io_wdata[23:2], 2'b00};
      if (ewb_write)
        enhanced_window_base_reg <= ewb_wdata;
    end
  end

  // Byte/word index accesses pass through as plain I/O on the chipset link
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      io_pass       <= 1'b0;
      io_pass_addr  <= 16'h0000;
      io_pass_be    <= 4'h0;
      io_pass_write <= 1'b0;
      io_pass_wdata <= 32'h0000_0000;
    end else begin
      io_pass <= idx_part;
      if (idx_part) begin
        io_pass_addr  <= io_addr;
        io_pass_be    <= io_be;
        io_pass_write <= io_write;
        io_pass_wdata <= io_wdata;
      end
    end
  end

  // Request issue and completion
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state       <= ST_IDLE;
      pend_posted <= 1'b0;
      cfg_req     <= 1'b0;
      cfg_route   <= `CAR_RT_NONE;
      cfg_write   <= 1'b0;
      cfg_be      <= 4'h0;
      cfg_wdata   <= 32'h0000_0000;
      cfg_hdr_dw2 <= 32'h0000_0000;
      cfg_bus     <= 8'h00;
      cfg_dev     <= 5'h00;
      cfg_func    <= 3'h0;
      cfg_offset  <= 10'h000;
      host_done   <= 1'b0;
      host_rdata  <= 32'h0000_0000;
      host_abort  <= 1'b0;
    end else begin
      cfg_req    <= 1'b0;
      host_done  <= 1'b0;
      host_abort <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (idx_dword) begin
            host_done  <= 1'b1;
            host_rdata <= io_write ? 32'h0000_0000 : config_index_port;
          end else if (io_data_hit && !io_cfg) begin
            host_done  <= 1'b1;
            host_rdata <= 32'hffff_ffff;
          end else if (start) begin
            if (route == `CAR_RT_ABORT || route == `CAR_RT_IGNORE) begin
              host_done  <= 1'b1;
              host_abort <= (route == `CAR_RT_ABORT);
              host_rdata <= 32'hffff_ffff;
            end else begin
              cfg_req     <= 1'b1;
              cfg_route   <= route;
              cfg_write   <= start_write;
              cfg_be      <= start_be;
              cfg_wdata   <= start_wdata;
              cfg_hdr_dw2 <= hdr;
              cfg_bus     <= bus;
              cfg_dev     <= dev;
              cfg_func    <= func;
              cfg_offset  <= {upper_idx, reg_num};
              pend_posted <= start_posted;
              if (start_posted)
                host_done <= 1'b1;
              state <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          if (cfg_done) begin
            state <= ST_IDLE;
            // Posted writes were answered at issue; only the wait ends here
            if (!pend_posted) begin
              host_done  <= 1'b1;
              host_abort <= cfg_abort;
              host_rdata <= cfg_abort ? 32'hffff_ffff : cfg_rdata;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // car_config_access_router

/* bench/car_router_monitor.sv */
/* Checker on the router's top ports: index decode, data window gating,
   routing and header packing. Assumes one clock and the async reset. */
`timescale 1ns/1ps
`include "car_defs.vh"
module car_router_monitor (
  input wire        clk,
  input wire        reset_n,
  input wire        io_req,
  input wire [15:0] io_addr,
  input wire [3:0]  io_be,
  input wire        host_busy,
  input wire        host_done,
  input wire        host_abort,
  input wire        io_pass,
  input wire [31:0] config_index_port,
  input wire        cfg_req,
  input wire [2:0]  cfg_route,
  input wire [31:0] cfg_hdr_dw2,
  input wire [7:0]  cfg_bus,
  input wire [4:0]  cfg_dev,
  input wire [2:0]  cfg_func,
  input wire [9:0]  cfg_offset,
  input wire [7:0]  sec_bus,
  input wire [7:0]  sub_bus
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire       idx_ok = io_req && !host_busy && io_addr == `CAR_IO_INDEX;
  wire       dat_ok = io_req && !host_busy && io_addr == `CAR_IO_DATA;
  wire [7:0] ix_bus = config_index_port[23:16];
  wire       ix_on  = config_index_port[31];
  property p_idx_dw; idx_ok && io_be == 4'hf |=> host_done && !cfg_req; endproperty
  a_idx_dw: assert property (p_idx_dw) else $error("index dword unanswered");
  property p_idx_part; idx_ok && io_be != 4'hf |=> io_pass && !host_done; endproperty
  a_idx_part: assert property (p_idx_part) else $error("partial index not passed");
  property p_off; dat_ok && !ix_on |=> host_done && !cfg_req; endproperty
  a_off: assert property (p_off) else $error("cycle while disabled");
  property p_link1;
    dat_ok && ix_on && ix_bus > sub_bus |=> cfg_req && cfg_route == `CAR_RT_LINK_T1;
  endproperty
  a_link1: assert property (p_link1) else $error("far bus not sent to link");
  property p_abort;
    dat_ok && ix_on && ix_bus == sec_bus && config_index_port[15:11] != 5'h0
      |=> host_abort && !cfg_req;
  endproperty
  a_abort: assert property (p_abort) else $error("nonzero device not aborted");
  property p_hdr;
    cfg_req |-> cfg_hdr_dw2 == {cfg_bus, cfg_dev, cfg_func, 4'h0, cfg_offset, 2'h0};
  endproperty
  a_hdr: assert property (p_hdr) else $error("header packing wrong");
  property p_t0;
    cfg_req && cfg_bus == sec_bus && cfg_bus != 8'h0
      |-> cfg_route == `CAR_RT_ROOT_T0 && cfg_dev == 5'h0;
  endproperty
  a_t0: assert property (p_t0) else $error("secondary bus route wrong");
  property p_t1;
    cfg_req && cfg_bus > sec_bus && cfg_bus <= sub_bus |-> cfg_route == `CAR_RT_ROOT_T1;
  endproperty
  a_t1: assert property (p_t1) else $error("claimed bus route wrong");
  property p_bus0;
    cfg_req && cfg_bus == 8'h0 && cfg_dev > 5'h1 |-> cfg_route == `CAR_RT_LINK_T0;
  endproperty
  a_bus0: assert property (p_bus0) else $error("bus zero device route wrong");
  c_pass: cover property (idx_ok && io_be != 4'hf);
  c_t1: cover property (cfg_req && cfg_route == `CAR_RT_ROOT_T1);
  c_abort: cover property (host_abort);
endmodule // car_router_monitor
bind car_config_access_router car_router_monitor u_car_router_monitor (
  .clk, .reset_n, .io_req, .io_addr, .io_be, .host_busy, .host_done, .host_abort, .io_pass,
  .config_index_port, .cfg_req, .cfg_route, .cfg_hdr_dw2, .cfg_bus, .cfg_dev, .cfg_func,
  .cfg_offset, .sec_bus, .sub_bus);

/* bench/car_cfg_responder.sv */
/* Downstream responder: answers each configuration request after a set
   delay. Assumes one request outstanding and offsets held until the next. */
`timescale 1ns/1ps
`include "car_defs.vh"
module car_cfg_responder #(
  parameter [7:0] DEAD_BUS = 8'h09
) (
  input wire        clk,
  input wire        reset_n,
  input wire        cfg_req,
  input wire [2:0]  cfg_route,
  input wire        cfg_write,
  input wire [31:0] cfg_wdata,
  input wire [7:0]  cfg_bus,
  input wire [9:0]  cfg_offset,
  input wire [3:0]  delay,
  output reg        cfg_done,
  output reg        cfg_abort,
  output reg [31:0] cfg_rdata
);
  reg [31:0] store [0:1023];
  reg [3:0]  cnt;
  reg [9:0]  off;
  reg        busy;
  reg        ab;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy      <= 1'b0;
      cnt       <= 4'h0;
      cfg_done  <= 1'b0;
      cfg_abort <= 1'b0;
      cfg_rdata <= 32'h0;
    end else begin
      cfg_done  <= 1'b0;
      cfg_abort <= 1'b0;
      // Stale data must not look valid outside an answer
      cfg_rdata <= ~cfg_rdata;
      if (cfg_req) begin
        busy <= 1'b1;
        cnt  <= delay;
        off  <= cfg_offset;
        ab   <= cfg_route == `CAR_RT_LINK_T1 && cfg_bus == DEAD_BUS;
        if (cfg_write)
          store[cfg_offset] <= cfg_wdata;
      end else if (busy && cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else if (busy) begin
        busy      <= 1'b0;
        cfg_done  <= 1'b1;
        cfg_abort <= ab;
        cfg_rdata <= ab ? 32'hffff_ffff : store[off];
      end
    end
  end
endmodule // car_cfg_responder

/* bench/car_config_access_router_test.sv */
/* Testbench: host I/O and memory accesses through shared tasks, checked
   against expected routes and data. Assumes the responder model downstream. */
`timescale 1ns/1ps
`include "car_defs.vh"
module car_config_access_router_test;
  reg         clk, reset_n, io_req, io_write, mem_req, mem_write, ewb_write, dev0_en, dev1_en;
  reg  [15:0] io_addr;
  reg  [3:0]  io_be, mem_be, dly;
  reg  [31:0] io_wdata, mem_wdata, ewb_wdata, rd, tix;
  reg  [35:0] mem_addr;
  reg  [7:0]  sec_bus, sub_bus;
  reg  [1:0]  window_size;
  reg  [2:0]  seen_rt, trt;
  reg         got_ab, got_pass, got_miss, posted, tab;
  wire        host_done, host_abort, host_busy, mem_miss, io_pass, cfg_req, cfg_write;
  wire        cfg_done, cfg_abort;
  wire [31:0] host_rdata, cfg_wdata, cfg_hdr_dw2, cfg_rdata, config_index_port;
  wire [2:0]  cfg_route, cfg_func;
  wire        io_pass_write;
  wire [3:0]  io_pass_be, cfg_be;
  wire [4:0]  cfg_dev;
  wire [15:0] io_pass_addr;
  wire [31:0] io_pass_wdata, ewb_reg;
  wire [7:0]  cfg_bus;
  wire [9:0]  cfg_offset;
  integer     miscompares, n_compared, n_req, n_dn, i, n0;
  car_config_access_router u_car_config_access_router (.clk, .reset_n, .io_req, .io_write,
    .io_addr, .io_be, .io_wdata, .mem_req, .mem_write, .mem_addr, .mem_be, .mem_wdata,
    .host_done, .host_rdata, .host_abort, .host_busy, .mem_miss, .io_pass, .io_pass_addr,
    .io_pass_be, .io_pass_write, .io_pass_wdata, .sec_bus, .sub_bus, .dev0_en,
    .dev1_en, .window_size, .ewb_write, .ewb_wdata, .enhanced_window_base_reg(ewb_reg),
    .cfg_req, .cfg_route, .cfg_write, .cfg_be, .cfg_wdata, .cfg_hdr_dw2, .cfg_bus, .cfg_dev,
    .cfg_func, .cfg_offset, .cfg_done, .cfg_abort, .cfg_rdata, .config_index_port);
  car_cfg_responder u_car_cfg_responder (.clk, .reset_n, .cfg_req, .cfg_route, .cfg_write,
    .cfg_wdata, .cfg_bus, .cfg_offset, .delay(dly), .cfg_done, .cfg_abort, .cfg_rdata);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    if (reset_n !== 1'b1) begin
      n_req <= 0;
      n_dn <= 0;
      seen_rt <= `CAR_RT_NONE;
    end else begin
      if (cfg_req === 1'b1) begin
        n_req <= n_req + 1;
        seen_rt <= cfg_route;
      end else if (io_req === 1'b1 || mem_req === 1'b1) begin
        seen_rt <= `CAR_RT_NONE;
      end
      if (cfg_done === 1'b1)
        n_dn <= n_dn + 1;
    end
  end
  task end_sim;
    begin
      $display("Compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task chk(input [31:0] s, input [31:0] e);
    begin
      n_compared = n_compared + 1;
      if (s !== e) begin
        miscompares = miscompares + 1;
        $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task tick(input integer k);
    begin
      if (k == 64) begin
        miscompares = miscompares + 1;
        end_sim;
      end else begin
        @(posedge clk);
        #1;
      end
    end
  endtask
  // One host access; returns after the answer and the downstream side settle
  task acc(input m, input w, input [35:0] a, input [3:0] be, input [31:0] d);
    integer k;
    begin
      @(posedge clk);
      n0 = n_dn;
      if (m) begin
        mem_req <= 1'b1;
        mem_write <= w;
        mem_addr <= a;
        mem_be <= be;
        mem_wdata <= d;
      end else begin
        io_req <= 1'b1;
        io_write <= w;
        io_addr <= a[15:0];
        io_be <= be;
        io_wdata <= d;
      end
      #1 got_miss = m && mem_miss === 1'b1;
      @(posedge clk);
      io_req <= 1'b0;
      mem_req <= 1'b0;
      #1;
      for (k = 0; !got_miss && host_done !== 1'b1 && io_pass !== 1'b1; k = k + 1)
        tick(k);
      got_ab = host_abort;
      got_pass = io_pass;
      rd = host_rdata;
      posted = n_dn == n0;
      for (k = 0; k == 0 || host_busy !== 1'b0 || n_req != n_dn; k = k + 1)
        tick(k);
    end
  endtask
  initial begin
    {reset_n, io_req, io_write, mem_req, mem_write, ewb_write, window_size} = 8'h0;
    {io_addr, io_be, io_wdata, mem_addr, mem_be, mem_wdata, ewb_wdata} = 156'h0;
    {sec_bus, sub_bus, dev0_en, dev1_en, dly} = {8'h01, 8'h04, 2'h3, 4'h1};
    {miscompares, n_compared} = 64'h0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    acc(0, 1, 36'hcf8, 4'hf, 32'hff01_0807);
    acc(0, 0, 36'hcf8, 4'hf, 32'h0);
    chk(rd, 32'h8001_0804);
    acc(0, 1, 36'hcf8, 4'h3, 32'h1234_5678);
    chk({31'h0, got_pass}, 32'h1);
    chk(config_index_port, 32'h8001_0804);
    chk({11'h0, io_pass_write, io_pass_be, io_pass_addr}, 32'h0013_0cf8);
    chk(io_pass_wdata, 32'h1234_5678);
    acc(0, 1, 36'hcf8, 4'hf, 32'h0000_0800);
    i = n_req;
    acc(0, 0, 36'hcfc, 4'hf, 32'h0);
    chk(rd, 32'hffff_ffff);
    chk(n_req, i);
    for (i = 0; i < 8; i = i + 1) begin
      case (i)
        0: {tix, trt, tab} = {32'h8000_0000, `CAR_RT_INTERNAL, 1'b0};
        1: {tix, trt, tab} = {32'h8000_0100, `CAR_RT_NONE, 1'b0};
        2: {tix, trt, tab} = {32'h8000_2800, `CAR_RT_LINK_T0, 1'b0};
        3: {tix, trt, tab} = {32'h8001_0000, `CAR_RT_ROOT_T0, 1'b0};
        4: {tix, trt, tab} = {32'h8001_1800, `CAR_RT_NONE, 1'b1};
        5: {tix, trt, tab} = {32'h8003_28fc, `CAR_RT_ROOT_T1, 1'b0};
        6: {tix, trt, tab} = {32'h8009_0000, `CAR_RT_LINK_T1, 1'b1};
        default: {tix, trt, tab} = {32'h8000_0800, `CAR_RT_LINK_T0, 1'b0};
      endcase
      dev1_en <= i != 7;
      acc(0, 1, 36'hcf8, 4'hf, tix);
      acc(0, 0, 36'hcfc, 4'hf, 32'h0);
      chk({29'h0, seen_rt}, {29'h0, trt});
      chk({31'h0, got_ab}, {31'h0, tab});
      if (i == 1)
        chk(rd, 32'hffff_ffff);
      if (i == 5) begin
        chk(cfg_hdr_dw2, 32'h0328_00fc);
        chk({20'h0, cfg_be, cfg_dev, cfg_func}, 32'h0000_0f28);
      end
    end
    dev1_en <= 1'b1;
    acc(1, 0, 36'h1_e010_0104, 4'hf, 32'h0);
    chk({31'h0, got_miss}, 32'h1);
    @(posedge clk);
    ewb_write <= 1'b1;
    ewb_wdata <= 32'h1e00_0001;
    @(posedge clk);
    ewb_write <= 1'b0;
    dly <= 4'h8;
    acc(1, 1, 36'h1_e010_0104, 4'hf, 32'ha5a5_1234);
    chk({31'h0, posted}, 32'h1);
    chk(ewb_reg, 32'h1e00_0001);
    chk({22'h0, cfg_offset}, 32'h041);
    acc(1, 0, 36'h1_e010_0104, 4'hf, 32'h0);
    chk(rd, 32'ha5a5_1234);
    acc(0, 1, 36'hcf8, 4'hf, 32'h8001_0008);
    acc(0, 1, 36'hcfc, 4'hf, 32'h5a5a_0f0f);
    chk({28'h0, cfg_offset[9:6]}, 32'h0);
    acc(1, 0, 36'h1_e010_0008, 4'hf, 32'h0);
    chk(rd, 32'h5a5a_0f0f);
    acc(1, 0, 36'h1_e400_0000, 4'hf, 32'h0);
    chk({31'h0, got_miss}, 32'h0);
    window_size <= 2'h2;
    acc(1, 0, 36'h1_e400_0000, 4'hf, 32'h0);
    chk({31'h0, got_miss}, 32'h1);
    acc(1, 0, 36'h1_e3f0_0000, 4'hf, 32'h0);
    chk({31'h0, got_miss}, 32'h0);
    end_sim;
  end
endmodule // car_config_access_router_test
